//--- core/txmod_defs.svh
`ifndef TXMOD_DEFS_SVH
`define TXMOD_DEFS_SVH
// Register offsets
`define ADDR_PIN_CFG_C      8'h00
`define ADDR_PIN_CFG_A      8'h01
`define ADDR_PKT_CTRL0      8'h02
`define ADDR_PKT_LEN        8'h03
`define ADDR_MDM_CFG2       8'h04
`define ADDR_MDM_CFG1       8'h05
`define ADDR_DEVIATION      8'h06
`define ADDR_ASK_DEPTH      8'h07
`define ADDR_COMMAND        8'h08
`define ADDR_FIFO_DATA      8'h09
`define ADDR_PKT_STATUS     8'h10
`define ADDR_FIFO_COUNT     8'h11
`define ADDR_RADIO_STATE    8'h12
// Field positions
`define WHITEN_BIT          6
`define MANCH_BIT           3
`define FEC_BIT             7
`define MODF_MSB            6
`define MODF_LSB            4
`define DEV_E_MSB           6
`define DEV_E_LSB           4
`define DEV_M_MSB           2
`define DEV_M_LSB           0
`define STAT_PIN_A_BIT      0
`define STAT_PIN_C_BIT      2
// Reset values
`define PIN_CFG_RST         8'h00
`define PKT_CTRL0_RST       8'h40
`define PKT_LEN_RST         8'h04
`define MDM_CFG2_RST        8'h00
`define MDM_CFG1_RST        8'h00
`define DEVIATION_RST       8'h47
`define ASK_DEPTH_RST       8'h40
// Selector codes and encodings
`define SEL_FIFO_THR        6'h02
`define SEL_FIFO_FULL       6'h03
`define SEL_SYNC_PKT        6'h06
`define MOD_2FSK            3'h0
`define MOD_GFSK            3'h1
`define MOD_ASK             3'h3
`define MOD_MSK             3'h7
`define CMD_TX              8'h01
`define CMD_IDLE            8'h02
`define CMD_FLUSH           8'h03
// Packet and coder constants
`define FIFO_DEPTH          7'h40
`define FIFO_THRESHOLD      7'h21
`define PREAMBLE_BYTES      8'h04
`define PREAMBLE_BYTE       8'hAA
`define SYNC_HI             8'hD3
`define SYNC_LO             8'h91
`define TERM_BYTE           8'h0B
`define CONV_POLY_A         4'b1011
`define CONV_POLY_B         4'b1101
`define PN9_SEED            9'h1FF
`define AMP_FULL            8'hFF
// State numbers shown to software
`define STNUM_IDLE          5'h01
`define STNUM_TX            5'h13
`define STNUM_END           5'h14
`define STNUM_UNDER         5'h16
`endif

//--- core/txmod_pkg.sv
`default_nettype none
package txmod_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SYNC, ST_DATA, ST_END, ST_UNDER} tx_state_t;
   typedef logic [7:0] byte_t;
endpackage : txmod_pkg
`default_nettype wire

//--- core/tx_modulation_fec_encoder.sv
// Decided for this implementation: the strobed register port and the address map.
`include "txmod_defs.svh"
`default_nettype none
module tx_modulation_fec_encoder
   import txmod_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic [7:0]          addr,
   input  wire logic [7:0]          wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [7:0]          rdata,
   output logic      [7:0]          status_byte,
   input  wire logic                sym_clk,
   output logic                     general_output_pin_a,
   output logic                     general_output_pin_c,
   output logic                     tx_symbol,
   output logic signed [11:0]       freq_offset,
   output logic                     pa_enable,
   output logic      [7:0]          pa_amplitude,
   output logic      [2:0]          msk_transition
);
   import txmod_pkg::*;

   byte_t       pin_cfg_c_reg, pin_cfg_a_reg, packet_control_zero, pkt_len_reg;
   byte_t       modem_config_second, modem_config_first, deviation_reg, ask_depth_reg;
   byte_t       fifo_mem [64];
   logic [5:0]  wr_ptr_reg, rd_ptr_reg;
   logic [6:0]  tx_fifo_count_reg;
   tx_state_t   state_reg;
   logic [7:0]  idx_reg;
   logic        half_reg;
   byte_t       hold_reg;
   logic [2:0]  conv_reg;
   logic [8:0]  pn9_reg;
   logic [31:0] chip_reg;
   logic [5:0]  chip_cnt_reg;
   logic        sync_seen_reg;
   logic        sym_meta_reg, sym_sync_reg, sym_prev_reg;
   logic [2:0]  hist_reg;
   logic [4:0]  radio_state_reg;

   logic        sym_en, push, pop, flush, cmd_tx, cmd_idle, load;
   logic [8:0]  total_bytes;
   byte_t       src_byte, white_byte;
   logic [15:0] pair;
   logic [31:0] coded;
   logic [2:0]  conv_next;
   logic [2:0]  mod_fmt;
   logic        fec_on, manch_on, whiten_on;
   logic [10:0] dev_step;
   logic [2:0]  gauss_sum;
   logic [7:0]  amp_target;

   assign mod_fmt   = modem_config_second[`MODF_MSB:`MODF_LSB];
   assign fec_on    = modem_config_first[`FEC_BIT];
   assign manch_on  = modem_config_second[`MANCH_BIT];
   assign whiten_on = packet_control_zero[`WHITEN_BIT];

   // Register writes and command strobes
   assign cmd_tx   = wr && addr == `ADDR_COMMAND && wdata == `CMD_TX;
   assign cmd_idle = wr && addr == `ADDR_COMMAND && wdata == `CMD_IDLE;
   assign flush    = wr && addr == `ADDR_COMMAND && wdata == `CMD_FLUSH;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_cfg_c_reg       <= `PIN_CFG_RST;
         pin_cfg_a_reg       <= `PIN_CFG_RST;
         packet_control_zero <= `PKT_CTRL0_RST;
         pkt_len_reg         <= `PKT_LEN_RST;
         modem_config_second <= `MDM_CFG2_RST;
         modem_config_first  <= `MDM_CFG1_RST;
         deviation_reg       <= `DEVIATION_RST;
         ask_depth_reg       <= `ASK_DEPTH_RST;
      end else if (wr) begin
         if (addr == `ADDR_PIN_CFG_C) begin
            pin_cfg_c_reg <= wdata;
         end else if (addr == `ADDR_PIN_CFG_A) begin
            pin_cfg_a_reg <= wdata;
         end else if (addr == `ADDR_PKT_CTRL0) begin
            packet_control_zero <= wdata;
         end else if (addr == `ADDR_PKT_LEN) begin
            pkt_len_reg <= wdata;
         end else if (addr == `ADDR_MDM_CFG2) begin
            modem_config_second <= wdata;
         end else if (addr == `ADDR_MDM_CFG1) begin
            modem_config_first <= wdata;
         end else if (addr == `ADDR_DEVIATION) begin
            deviation_reg <= wdata;
         end else if (addr == `ADDR_ASK_DEPTH) begin
            ask_depth_reg <= wdata;
         end
      end
   end

   // Read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (addr == `ADDR_PIN_CFG_C) begin
            rdata <= pin_cfg_c_reg;
         end else if (addr == `ADDR_PIN_CFG_A) begin
            rdata <= pin_cfg_a_reg;
         end else if (addr == `ADDR_PKT_CTRL0) begin
            rdata <= packet_control_zero;
         end else if (addr == `ADDR_PKT_LEN) begin
            rdata <= pkt_len_reg;
         end else if (addr == `ADDR_MDM_CFG2) begin
            rdata <= modem_config_second;
         end else if (addr == `ADDR_MDM_CFG1) begin
            rdata <= modem_config_first;
         end else if (addr == `ADDR_DEVIATION) begin
            rdata <= deviation_reg;
         end else if (addr == `ADDR_ASK_DEPTH) begin
            rdata <= ask_depth_reg;
         end else if (addr == `ADDR_PKT_STATUS) begin
            rdata <= {5'h00, general_output_pin_c, 1'b0, general_output_pin_a};
         end else if (addr == `ADDR_FIFO_COUNT) begin
            rdata <= {1'b0, tx_fifo_count_reg};
         end else if (addr == `ADDR_RADIO_STATE) begin
            rdata <= {3'h0, radio_state_reg};
         end else begin
            rdata <= 8'h00;
         end
      end
   end

   // Status byte refreshed on every access: state bits and saturated count
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_byte <= 8'h00;
      end else if (rd || wr) begin
         status_byte <= {1'b0, state_reg, (tx_fifo_count_reg > 7'h0F) ? 4'hF : tx_fifo_count_reg[3:0]};
      end
   end

   // Transmit FIFO; a push while full is dropped so the count stays honest
   assign push = wr && addr == `ADDR_FIFO_DATA && tx_fifo_count_reg != `FIFO_DEPTH;

   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg        <= 6'h00;
         rd_ptr_reg        <= 6'h00;
         tx_fifo_count_reg <= 7'h00;
      end else if (flush) begin
         wr_ptr_reg        <= 6'h00;
         rd_ptr_reg        <= 6'h00;
         tx_fifo_count_reg <= 7'h00;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 6'h01;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 6'h01;
         end
         if (push && !pop) begin
            tx_fifo_count_reg <= tx_fifo_count_reg + 7'h01;
         end else if (pop && !push) begin
            tx_fifo_count_reg <= tx_fifo_count_reg - 7'h01;
         end
      end
   end

   // Symbol clock arrives from another domain; first flop feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sym_meta_reg <= 1'b0;
         sym_sync_reg <= 1'b0;
         sym_prev_reg <= 1'b0;
      end else begin
         sym_meta_reg <= sym_clk;
         sym_sync_reg <= sym_meta_reg;
         sym_prev_reg <= sym_sync_reg;
      end
   end
   assign sym_en = sym_sync_reg && !sym_prev_reg;

   // Byte source: payload from the FIFO, then termination bytes when FEC is on
   assign total_bytes = fec_on ? ({1'b0, pkt_len_reg} + (pkt_len_reg[0] ? 9'd1 : 9'd2))
                               : {1'b0, pkt_len_reg};
   assign src_byte   = (idx_reg < pkt_len_reg) ? fifo_mem[rd_ptr_reg] : `TERM_BYTE;
   assign white_byte = whiten_on ? (src_byte ^ pn9_reg[7:0]) : src_byte;
   assign pair       = {hold_reg, white_byte};
   assign load       = chip_cnt_reg == 6'h00;
   assign pop        = load && state_reg == ST_DATA && idx_reg < pkt_len_reg && tx_fifo_count_reg != 7'h00;

   // Interleave rows-in columns-out, then convolutional coding with three memory bits
   always_comb begin
      logic [2:0] cs;
      logic       b;
      b     = 1'b0;
      cs    = conv_reg;
      coded = 32'h0000_0000;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            b = pair[15 - (4 * r + c)];
            coded[31 - 2 * (4 * c + r)] = ^({b, cs} & `CONV_POLY_A);
            coded[30 - 2 * (4 * c + r)] = ^({b, cs} & `CONV_POLY_B);
            cs = {b, cs[2:1]};
         end
      end
      conv_next = cs;
   end

   function automatic logic [31:0] manch(input byte_t d);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
         m[31 - 2 * i] = d[7 - i];
         m[30 - 2 * i] = !d[7 - i];
      end
      return m;
   endfunction : manch

   function automatic logic [8:0] pn9_adv8(input logic [8:0] s);
      logic [8:0] v;
      v = s;
      for (int i = 0; i < 8; i++) begin
         v = {v[5] ^ v[0], v[8:1]};
      end
      return v;
   endfunction : pn9_adv8

   // Frame sequencer: loads a chip unit whenever the chip register runs dry
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg     <= ST_IDLE;
         idx_reg       <= 8'h00;
         half_reg      <= 1'b0;
         hold_reg      <= 8'h00;
         conv_reg      <= 3'h0;
         pn9_reg       <= `PN9_SEED;
         chip_reg      <= 32'h0000_0000;
         chip_cnt_reg  <= 6'h00;
         sync_seen_reg <= 1'b0;
      end else if (cmd_idle || (flush && state_reg == ST_UNDER)) begin
         state_reg     <= ST_IDLE;
         chip_cnt_reg  <= 6'h00;
         sync_seen_reg <= 1'b0;
      end else if (load) begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_tx) begin
                  state_reg <= ST_PRE;
                  idx_reg   <= 8'h00;
               end
            end
            ST_PRE: begin
               chip_reg     <= {`PREAMBLE_BYTE, 24'h00_0000};
               chip_cnt_reg <= 6'd8;
               if (idx_reg != `PREAMBLE_BYTES) begin
                  idx_reg <= idx_reg + 8'h01;
               end
               // Preamble keeps running until the host has queued a byte
               if (idx_reg + 8'h01 >= `PREAMBLE_BYTES && tx_fifo_count_reg != 7'h00) begin
                  state_reg <= ST_SYNC;
                  idx_reg   <= 8'h00;
               end
            end
            ST_SYNC: begin
               chip_reg     <= {(idx_reg == 8'h00) ? `SYNC_HI : `SYNC_LO, 24'h00_0000};
               chip_cnt_reg <= 6'd8;
               idx_reg      <= idx_reg + 8'h01;
               if (idx_reg != 8'h00) begin
                  state_reg     <= ST_DATA;
                  idx_reg       <= 8'h00;
                  half_reg      <= 1'b0;
                  conv_reg      <= 3'h0;
                  pn9_reg       <= `PN9_SEED;
               end
            end
            ST_DATA: begin
               // First data load comes only after the last sync chip has gone out
               sync_seen_reg <= 1'b1;
               if (idx_reg < pkt_len_reg && tx_fifo_count_reg == 7'h00) begin
                  state_reg <= ST_UNDER;
               end else begin
                  idx_reg <= idx_reg + 8'h01;
                  pn9_reg <= pn9_adv8(pn9_reg);
                  if (fec_on && !half_reg) begin
                     hold_reg <= white_byte;
                     half_reg <= 1'b1;
                  end else if (fec_on) begin
                     chip_reg     <= coded;
                     chip_cnt_reg <= 6'd32;
                     conv_reg     <= conv_next;
                     half_reg     <= 1'b0;
                  end else if (manch_on) begin
                     chip_reg     <= manch(white_byte);
                     chip_cnt_reg <= 6'd16;
                  end else begin
                     chip_reg     <= {white_byte, 24'h00_0000};
                     chip_cnt_reg <= 6'd8;
                  end
                  if ({1'b0, idx_reg} + 9'd1 >= total_bytes) begin
                     state_reg <= ST_END;
                  end
               end
            end
            ST_END: begin
               state_reg     <= ST_IDLE;
               sync_seen_reg <= 1'b0;
            end
            default: begin
               state_reg <= ST_UNDER;
            end
         endcase
      end else if (sym_en) begin
         chip_reg     <= {chip_reg[30:0], 1'b0};
         chip_cnt_reg <= chip_cnt_reg - 6'h01;
      end
   end

   always_comb begin
      case (state_reg)
         ST_IDLE:  radio_state_reg = `STNUM_IDLE;
         ST_END:   radio_state_reg = `STNUM_END;
         ST_UNDER: radio_state_reg = `STNUM_UNDER;
         default:  radio_state_reg = `STNUM_TX;
      endcase
   end

   // Output pins, each picking its signal by its select field
   function automatic logic pin_src(input logic [5:0] sel, input logic [6:0] cnt, input logic sy);
      if (sel == `SEL_SYNC_PKT) begin
         return sy;
      end else if (sel == `SEL_FIFO_THR) begin
         return cnt >= `FIFO_THRESHOLD;
      end else if (sel == `SEL_FIFO_FULL) begin
         return cnt == `FIFO_DEPTH;
      end
      return 1'b0;
   endfunction : pin_src

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         general_output_pin_a <= 1'b0;
         general_output_pin_c <= 1'b0;
      end else begin
         general_output_pin_a <= pin_src(pin_cfg_a_reg[5:0], tx_fifo_count_reg, sync_seen_reg);
         general_output_pin_c <= pin_src(pin_cfg_c_reg[5:0], tx_fifo_count_reg, sync_seen_reg);
      end
   end

   // Modulator: one chip per symbol enable while a frame is on air
   // Widen before shifting so the exponent cannot push bits off a 4-bit mantissa
   assign dev_step  = {7'h00, 4'd8 + {1'b0, deviation_reg[`DEV_M_MSB:`DEV_M_LSB]}}
                          << deviation_reg[`DEV_E_MSB:`DEV_E_LSB];
   assign gauss_sum = 3'({2'b00, hist_reg[0]} + {1'b0, hist_reg[1], 1'b0} + {2'b00, hist_reg[2]});
   assign amp_target = (mod_fmt == `MOD_ASK && !tx_symbol) ? ask_depth_reg : `AMP_FULL;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_symbol <= 1'b0;
         hist_reg  <= 3'h0;
      end else if (sym_en && state_reg != ST_IDLE && state_reg != ST_UNDER) begin
         tx_symbol <= (mod_fmt == `MOD_MSK) ? !chip_reg[31] : chip_reg[31];
         hist_reg  <= {hist_reg[1:0], chip_reg[31]};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_offset    <= 12'sh000;
         pa_enable      <= 1'b0;
         pa_amplitude   <= 8'h00;
         msk_transition <= 3'h0;
      end else begin
         msk_transition <= deviation_reg[`DEV_M_MSB:`DEV_M_LSB];
         pa_enable      <= state_reg != ST_IDLE && state_reg != ST_UNDER
                           && (mod_fmt != `MOD_ASK || tx_symbol || ask_depth_reg != 8'h00);
         // Amplitude walks one step per clock to soften the keying edges
         if (pa_amplitude < amp_target) begin
            pa_amplitude <= pa_amplitude + 8'h01;
         end else if (pa_amplitude > amp_target) begin
            pa_amplitude <= pa_amplitude - 8'h01;
         end
         if (mod_fmt == `MOD_ASK) begin
            freq_offset <= 12'sh000;
         end else if (mod_fmt == `MOD_GFSK) begin
            // Three-tap 1-2-1 smoothing approximates the BT=1 Gaussian at one sample per symbol
            case (gauss_sum)
               3'd0:    freq_offset <= -$signed({1'b0, dev_step});
               3'd1:    freq_offset <= -$signed({2'b00, dev_step[10:1]});
               3'd3:    freq_offset <= $signed({2'b00, dev_step[10:1]});
               3'd4:    freq_offset <= $signed({1'b0, dev_step});
               default: freq_offset <= 12'sh000;
            endcase
         end else begin
            freq_offset <= tx_symbol ? $signed({1'b0, dev_step}) : -$signed({1'b0, dev_step});
         end
      end
   end
endmodule : tx_modulation_fec_encoder
`default_nettype wire

//--- dv/txmod_sva.sv
`default_nettype none
module txmod_sva (
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic [7:0]        addr,
   input wire logic [7:0]        wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [7:0]        rdata,
   input wire logic [7:0]        status_byte,
   input wire logic              general_output_pin_a,
   input wire logic              general_output_pin_c,
   input wire logic              tx_symbol,
   input wire logic signed [11:0] freq_offset,
   input wire logic              pa_enable,
   input wire logic [2:0]        msk_transition
);
   logic [2:0]  fmt;
   logic [2:0]  de;
   logic [2:0]  dm;
   logic        ask;
   logic [11:0] dv;
   // Shadow of format and deviation, seen from the register writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt <= 3'h0;
         de  <= 3'h4;
         dm  <= 3'h7;
      end else if (wr && addr == 8'h04) begin
         fmt <= wdata[6:4];
      end else if (wr && addr == 8'h06) begin
         de <= wdata[6:4];
         dm <= wdata[2:0];
      end
   end
   assign ask = (fmt == 3'h3);
   assign dv  = {8'h00, 4'h8 + {1'b0, dm}} << de;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_status;
      rd && addr == 8'h11 |=> !status_byte[7] && status_byte[3:0] == ((rdata > 8'h0F) ? 4'hF : rdata[3:0]);
   endproperty
   a_status: assert property (p_status)
      else $error("status byte count differs from count read");
   property p_pins;
      rd && addr == 8'h10 |=> rdata[0] == $past(general_output_pin_a) && rdata[2] == $past(general_output_pin_c);
   endproperty
   a_pins: assert property (p_pins)
      else $error("packet status does not show pin levels");
   property p_fsk;
      fmt == 3'h0 && pa_enable && $past(pa_enable, 3) |-> freq_offset == ($past(tx_symbol) ? dv : 12'h000 - dv);
   endproperty
   a_fsk: assert property (p_fsk)
      else $error("frequency offset wrong for chip");
   property p_ask;
      ask && $past(ask, 2) && pa_enable && $past(pa_enable, 3) |-> freq_offset == 12'h000;
   endproperty
   a_ask: assert property (p_ask)
      else $error("deviation present in amplitude mode");
   property p_msk;
      wr && addr == 8'h06 |=> ##1 msk_transition == dm;
   endproperty
   a_msk: assert property (p_msk)
      else $error("transition fraction not from mantissa");
   property p_idle_st;
      wr && addr == 8'h08 && wdata == 8'h02 ##[1:2] (rd || wr) |=> status_byte[6:4] == 3'h0;
   endproperty
   a_idle_st: assert property (p_idle_st)
      else $error("idle command did not reach idle");
   property p_idle_pa;
      wr && addr == 8'h08 && wdata == 8'h02 |-> ##[1:3] !pa_enable;
   endproperty
   a_idle_pa: assert property (p_idle_pa)
      else $error("amplifier still on after idle");
   property p_flush;
      wr && addr == 8'h08 && wdata == 8'h03 ##[1:2] (rd && addr == 8'h11) |=> rdata == 8'h00;
   endproperty
   a_flush: assert property (p_flush)
      else $error("count not zero after flush");
   c_fsk: cover property (fmt == 3'h0 && pa_enable);
   c_ask: cover property (ask && pa_enable);
   c_flag: cover property ($rose(general_output_pin_c));
endmodule : txmod_sva
bind tx_modulation_fec_encoder txmod_sva txmod_sva_inst (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
   .status_byte, .general_output_pin_a, .general_output_pin_c, .tx_symbol, .freq_offset, .pa_enable,
   .msk_transition);
`default_nettype wire

//--- dv/sym_src.sv
`default_nettype none
module sym_src (
   input wire logic   run,
   input wire logic   tx_symbol,
   output logic       sym_clk,
   output logic [31:0] win = 32'h0000_0000,
   output logic [15:0] chips = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands still between frames; odd start keeps it off the core clock phase
   initial begin
      sym_clk = 1'b0;
      #3;
      forever begin
         #80;
         if (run || sym_clk) sym_clk = ~sym_clk;
      end
   end
   always @(posedge sym_clk) begin
      win <= {win[30:0], tx_symbol};
      chips <= chips + 16'h0001;
   end
endmodule : sym_src
`default_nettype wire

//--- dv/tx_modulation_fec_encoder_tb_top.sv
`default_nettype none
module tx_modulation_fec_encoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, status_byte, pa_amplitude, q;
   logic general_output_pin_a, general_output_pin_c, tx_symbol, pa_enable, sym_clk;
   logic signed [11:0] freq_offset;
   logic [2:0] msk_transition;
   logic [31:0] win;
   logic [15:0] chips, c0;
   int fails = 0, samples_checked = 0, k;
   logic [7:0] ra [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h20, 8'h0C};
   logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h40, 8'h04, 8'h00, 8'h00, 8'h47, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
   logic [7:0] m2 [6] = '{8'h00, 8'h10, 8'h08, 8'h70, 8'h30, 8'h00};
   logic [7:0] m1 [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
   logic [31:0] pt [6] = '{32'hAAAA_D391, 32'hAAAA_D391, 32'hAAAA_D391, 32'h5555_2C6E, 32'hAAAA_D391, 32'hAAAA_D391};
   int nc [6] = '{16, 16, 32, 16, 16, 64};
   always #10 clk = ~clk;
   tx_modulation_fec_encoder tx_modulation_fec_encoder_inst (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
      .status_byte, .sym_clk, .general_output_pin_a, .general_output_pin_c, .tx_symbol, .freq_offset,
      .pa_enable, .pa_amplitude, .msk_transition);
   sym_src sym_src_inst (.run, .tx_symbol, .sym_clk, .win, .chips);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask : chk1
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr8
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
      chk8(q, e);
   endtask : rchk
   // Waits on the flag pin; in on-off keying a long zero chip must switch the amplifier off
   task automatic wait_pin(input logic lv, input logic ook);
      int i;
      int z;
      z = 0;
      for (i = 0; i < 6000 && general_output_pin_c !== lv; i++) begin
         @(posedge clk);
         z = (tx_symbol === 1'b0) ? z + 1 : 0;
         if (ook && z == 4) chk1(pa_enable, 1'b0);
      end
      if (general_output_pin_c !== lv) begin
         fails++;
         $display("unexpected at %0t: flag pin wait ran out", $time);
         end_sim();
      end
   endtask : wait_pin
   task automatic run_frame(input int n);
      wr8(8'h04, m2[n]);
      wr8(8'h05, m1[n]);
      wr8(8'h09, 8'h5A);
      wr8(8'h09, 8'hC3);
      wr8(8'h08, 8'h01);
      run <= 1'b1;
      wait_pin(1'b1, 1'b0);
      c0 = chips;
      // The last sync chip reaches the window at the next symbol clock edge
      @(posedge sym_clk);
      #1;
      chk1(win === pt[n], 1'b1);
      wait_pin(1'b0, m2[n] == 8'h30);
      chk1(int'(chips - c0) inside {[nc[n] - 2 : nc[n] + 2]}, 1'b1);
      run <= 1'b0;
      wr8(8'h08, 8'h02);
      rchk(8'h12, 8'h01);
      wr8(8'h08, 8'h03);
      $display("test frame %0d done", n);
   endtask : run_frame
   initial begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      for (k = 0; k < 13; k++) rchk(ra[k], rv[k]);
      $display("test reset_values done");
      for (k = 0; k < 3; k++) wr8(8'h09, 8'(k));
      rchk(8'h11, 8'h03);
      chk8(status_byte, 8'h03);
      wr8(8'h00, 8'h02);
      wr8(8'h01, 8'h03);
      for (k = 3; k < 65; k++) wr8(8'h09, 8'(k));
      rchk(8'h10, 8'h05);
      rchk(8'h11, 8'h40);
      wr8(8'h08, 8'h03);
      rchk(8'h11, 8'h00);
      rchk(8'h10, 8'h00);
      $display("test fifo_levels done");
      wr8(8'h06, 8'h23);
      wr8(8'h07, 8'h00);
      wr8(8'h03, 8'h02);
      wr8(8'h00, 8'h06);
      for (k = 0; k < 6; k++) run_frame(k);
      wr8(8'h03, 8'h04);
      wr8(8'h09, 8'h11);
      wr8(8'h08, 8'h01);
      run <= 1'b1;
      repeat (1000) @(posedge clk);
      run <= 1'b0;
      rchk(8'h12, 8'h16);
      chk8(pa_amplitude, 8'hFF);
      wr8(8'h08, 8'h03);
      rchk(8'h12, 8'h01);
      $display("test underflow done");
      end_sim();
   end
endmodule : tx_modulation_fec_encoder_tb_top
`default_nettype wire
